// ### dv/banked_sfr_register_map_tb_top.sv
// Self-checking bench of the banked register file
`timescale 1ns/100ps
`default_nettype none
module banked_sfr_register_map_tb_top;
  logic clock, nrst, upd, pd, wr_en, rd_en, bsel_o, por, bsel;
  logic [7:0] live, rdata, nout, d, wdata;
  logic [5:0] hw, sout, addr;
  logic [7:0] mdl [64];
  logic [7:0] b1 [64];
  int n_mismatch, total_checks, seed;
  sfrb_host i_host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  sfrb_regfile i_dut (.clock(clock), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .live_status(live), .subband_upd(upd), .subband_hw(hw), .power_down(pd),
    .rdata(rdata), .bank_sel_out(bsel_o), .narrow_ctrl_out(nout), .subband_out(sout));
  function automatic logic [7:0] ex(input logic [5:0] a);
    case (a)
      6'h00: return {7'h00, por};
      6'h01: return live;
      6'h02: return mdl[a] & 8'h0F;
      6'h03: return mdl[a] & 8'h3F;
      6'h3F: return {7'h00, bsel};
      default: return (bsel && a >= 6'h2E) ? b1[a] : mdl[a];
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp || $isunknown(exp))
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [7:0] v);
    i_host.wr(a, v);
    if (a == 6'h3F) bsel = v[0];
    else if (bsel && a >= 6'h2E) b1[a] = v;
    else if (a != 6'h01) mdl[a] = v;
  endtask
  task automatic r(input logic [5:0] a);
    logic [7:0] e;
    e = ex(a);
    i_host.rd(a, d);
    chk(d, e);
    if (a == 6'h00) por = 1'b0;
  endtask
  task automatic rst();
    nrst = 1'b0;
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    por = 1'b1;
    bsel = 1'b0;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    #5000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    seed = 32'h6AC3;
    {upd, pd, hw, live} = '0;
    rst();
    r(6'h00);
    r(6'h00);
    r(6'h3F);
    for (int b = 0; b < 2; b++)
    begin
      w(6'h3F, 8'(b));
      for (int i = 'h2E; i <= 'h3E; i++) w(6'(i), (i == 'h2E) ? 8'(b) : 8'($random(seed)));
    end
    for (int b = 0; b < 2; b++)
    begin
      w(6'h3F, 8'(b));
      @(negedge clock);
      chk({7'h00, bsel_o}, 8'(b));
      for (int i = 'h2E; i <= 'h3E; i++) r(6'(i));
      r(6'h3F);
    end
    w(6'h3F, 8'h00);
    bsel = 1'b0;
    for (int i = 'h2E; i <= 'h3E; i++) w(6'(i), 8'($random(seed)));
    w(6'h3F, 8'h01);
    for (int i = 'h2E; i <= 'h3E; i++) w(6'(i), 8'($random(seed)));
    foreach (mdl[i]) if (i >= 4 && i <= 'h2D) w(6'(i), 8'($random(seed)));
    foreach (mdl[i]) if (i >= 4) r(6'(i));
    repeat (3)
    begin
      live = 8'($random(seed));
      w(6'h01, 8'($random(seed)));
      r(6'h01);
    end
    w(6'h02, 8'hFF);
    r(6'h02);
    chk(nout, 8'h0F);
    w(6'h03, 8'($random(seed)));
    r(6'h03);
    hw = 6'($random(seed));
    upd = 1'b1;
    @(negedge clock);
    upd = 1'b0;
    mdl[3] = {2'b00, hw};
    r(6'h03);
    chk({2'b00, sout}, {2'b00, hw});
    hw = 6'($random(seed));
    fork
      w(6'h03, 8'($random(seed)));
      begin
        @(negedge clock);
        upd = 1'b1;
        @(negedge clock);
        upd = 1'b0;
      end
    join
    mdl[3] = {2'b00, hw};
    r(6'h03);
    pd = 1'b1;
    repeat (20) @(negedge clock);
    r(6'h02);
    r(6'h03);
    r(6'h3F);
    pd = 1'b0;
    rst();
    r(6'h00);
    r(6'h3F);
    tally_and_finish();
  end
endmodule // banked_sfr_register_map_tb_top
`default_nettype wire

// ### dv/sfrb_host.sv
// Host model acting as master of the register access strobes
`timescale 1ns/100ps
`default_nettype none
module sfrb_host (
  input wire logic clock, // System clock
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  output logic [5:0] addr, // Register address
  output logic [7:0] wdata, // Write data
  input wire logic [7:0] rdata // Registered read data
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never pass as valid
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clock);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clock);
    rd_en = 1'b1;
    addr = a;
    @(negedge clock);
    rd_en = 1'b0;
    addr = ~a;
    @(negedge clock);
    d = rdata;
  endtask
endmodule // sfrb_host
`default_nettype wire

// ### rtl/sfrb_decode.sv
// Address decoder steering the upper window to one of two banks
`timescale 1ns/100ps
`default_nettype none
`include "sfrb_params.svh"
module sfrb_decode (
  sfrb_decode_if.dec dif // Address in, region and bank index out
);
  always_comb
  begin
    dif.index = 5'(dif.addr - `SFRB_BANK_FIRST);
    if (dif.addr == `SFRB_BANK_SEL_ADDR)
      dif.region = sfrb_pkg::SFRB_SEL;
    else if (dif.addr <= `SFRB_LOW_TOP)
      dif.region = sfrb_pkg::SFRB_LOW;
    else if (dif.bank_sel)
      dif.region = sfrb_pkg::SFRB_BANK1;
    else
      dif.region = sfrb_pkg::SFRB_BANK0;
  end
endmodule // sfrb_decode
`default_nettype wire

// ### rtl/sfrb_decode_if.sv
// Decoded access carried between the top and the address decoder
`timescale 1ns/100ps
`default_nettype none
interface sfrb_decode_if;
  logic [5:0] addr;
  logic bank_sel;
  sfrb_pkg::sfrb_region_t region;
  logic [4:0] index;
  modport dec (input addr, input bank_sel, output region, output index);
  modport top (output addr, output bank_sel, input region, input index);
endinterface
`default_nettype wire

// ### rtl/sfrb_params.svh
// Address map, field positions and reset values of the banked register file
`ifndef SFRB_PARAMS_SVH
`define SFRB_PARAMS_SVH
`define SFRB_ADDR_W 6
`define SFRB_LOW_TOP 6'h2D
`define SFRB_BANK_FIRST 6'h2E
`define SFRB_BANK_LAST 6'h3E
`define SFRB_BANK_SEL_ADDR 6'h3F
`define SFRB_BANK_SEL_BIT 0
`define SFRB_BANK_SEL_RST 1'b0
`define SFRB_POR_FLAG_RST 1'b1
`define SFRB_SUBBAND_RST 6'h00
`define SFRB_EVENT_FLAG_ADDR 6'h00
`define SFRB_POR_FLAG_BIT 0
`define SFRB_STATUS_ADDR 6'h01
`define SFRB_NARROW_ADDR 6'h02
`define SFRB_NARROW_MASK 8'h0F
`define SFRB_SUBBAND_ADDR 6'h03
`define SFRB_SUBBAND_MASK 8'h3F
`define SFRB_RESERVED_ADDR 6'h04
`define SFRB_CTRL_RST 8'h00
`endif

// ### rtl/sfrb_pkg.sv
// Types shared by the banked register file
package sfrb_pkg;
  typedef logic [7:0] sfrb_byte_t;
  typedef logic [5:0] sfrb_addr_t;
  typedef enum logic [1:0] {SFRB_LOW, SFRB_BANK0, SFRB_BANK1, SFRB_SEL} sfrb_region_t;
endpackage

// ### rtl/sfrb_regfile.sv
// Banked special function register file with status, narrow and reserved registers
`timescale 1ns/100ps
`default_nettype none
`include "sfrb_params.svh"
module sfrb_regfile #(
  parameter int BANK_DEPTH = 17 // Registers per upper bank, 2Eh..3Eh
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic nrst, // Power-on reset, active low
  input wire logic wr_en, // Write strobe from serial interface
  input wire logic rd_en, // Read strobe from serial interface
  input wire logic [5:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic [7:0] live_status, // Live state machine status
  input wire logic subband_upd, // Hardware sub-band update strobe
  input wire logic [5:0] subband_hw, // Sub-band value from calibration
  input wire logic power_down, // Device in power-down
  output logic [7:0] rdata, // Registered read data
  output logic bank_sel_out, // Current bank select
  output logic [7:0] narrow_ctrl_out, // Narrow control register value
  output logic [5:0] subband_out // Oscillator sub-band field
);
  sfrb_decode_if dif ();
  sfrb_decode u_dec (.dif(dif));

  // Bank memories carry no reset; the host must write them before relying on a read
  sfrb_pkg::sfrb_byte_t bank0_mem [BANK_DEPTH];
  sfrb_pkg::sfrb_byte_t bank1_mem [BANK_DEPTH];
  sfrb_pkg::sfrb_byte_t low_mem [`SFRB_LOW_TOP + 1];
  logic bank_sel_reg;
  logic por_flag_reg;
  logic [7:0] narrow_reg;
  logic [5:0] subband_reg;
  logic [7:0] reserved_reg;
  logic rd_event;
  logic flag_rd;
  logic [7:0] rdata_next;

  assign dif.addr = addr;
  assign dif.bank_sel = bank_sel_reg;
  assign rd_event = rd_en && (addr == `SFRB_EVENT_FLAG_ADDR);
  assign flag_rd = rd_event;

  // Power-down gates no write: held state is simply not disturbed
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      bank_sel_reg <= `SFRB_BANK_SEL_RST;
    else if (wr_en && dif.region == sfrb_pkg::SFRB_SEL)
      bank_sel_reg <= wdata[`SFRB_BANK_SEL_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (wr_en && dif.region == sfrb_pkg::SFRB_BANK0)
      bank0_mem[dif.index] <= wdata;
    if (wr_en && dif.region == sfrb_pkg::SFRB_BANK1)
      bank1_mem[dif.index] <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (wr_en && dif.region == sfrb_pkg::SFRB_LOW && addr > `SFRB_RESERVED_ADDR)
      low_mem[addr] <= wdata;
  end

  // Read of the flag clears it after the value has been captured
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      por_flag_reg <= `SFRB_POR_FLAG_RST;
    else if (flag_rd)
      por_flag_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      narrow_reg <= `SFRB_CTRL_RST;
    else if (wr_en && addr == `SFRB_NARROW_ADDR)
      narrow_reg <= wdata & `SFRB_NARROW_MASK;
  end

  // Hardware update wins over a host write in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      subband_reg <= `SFRB_SUBBAND_RST;
    else if (subband_upd)
      subband_reg <= subband_hw;
    else if (wr_en && addr == `SFRB_SUBBAND_ADDR)
      subband_reg <= wdata[5:0];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reserved_reg <= `SFRB_CTRL_RST;
    else if (wr_en && addr == `SFRB_RESERVED_ADDR)
      reserved_reg <= wdata;
  end

  always_comb
  begin
    rdata_next = 8'h00;
    case (dif.region)
      sfrb_pkg::SFRB_SEL: rdata_next = {7'h00, bank_sel_reg};
      sfrb_pkg::SFRB_BANK0: rdata_next = bank0_mem[dif.index];
      sfrb_pkg::SFRB_BANK1: rdata_next = bank1_mem[dif.index];
      sfrb_pkg::SFRB_LOW:
      begin
        case (addr)
          `SFRB_EVENT_FLAG_ADDR: rdata_next = {7'h00, por_flag_reg};
          `SFRB_STATUS_ADDR: rdata_next = live_status;
          `SFRB_NARROW_ADDR: rdata_next = narrow_reg;
          `SFRB_SUBBAND_ADDR: rdata_next = {2'h0, subband_reg};
          `SFRB_RESERVED_ADDR: rdata_next = reserved_reg;
          default: rdata_next = low_mem[addr];
        endcase
      end
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data holds between reads so a slow host may pick it up late
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd_en)
      rdata <= rdata_next;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      bank_sel_out <= 1'b0;
      narrow_ctrl_out <= 8'h00;
      subband_out <= 6'h00;
    end
    else
    begin
      bank_sel_out <= bank_sel_reg;
      narrow_ctrl_out <= narrow_reg;
      subband_out <= subband_reg;
    end
  end

  // Checks other than the rdata readback ones watch the registers, the decoder region and bank_sel_out directly, so a fault shows before the host reads it
  sel_write_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && addr == `SFRB_BANK_SEL_ADDR |=> bank_sel_reg == $past(wdata[0]))
    else $error("bank select not written");
  sel_rdback_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && addr == `SFRB_BANK_SEL_ADDR |=> rdata == {7'h00, $past(bank_sel_reg)})
    else $error("bank select readback wrong");
  status_live_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && addr == `SFRB_STATUS_ADDR |=> rdata == $past(live_status))
    else $error("status read not live");
  status_nowr_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && addr == `SFRB_STATUS_ADDR && !subband_upd
    |=> $stable(narrow_reg) && $stable(subband_reg) && $stable(reserved_reg))
    else $error("status write reached storage");
  narrow_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    (narrow_reg & ~`SFRB_NARROW_MASK) == 8'h00)
    else $error("unimplemented bit stored");
  narrow_wr_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && addr == `SFRB_NARROW_ADDR |=> narrow_reg == ($past(wdata) & `SFRB_NARROW_MASK))
    else $error("narrow control write wrong");
  subband_hw_a: assert property (@(posedge clock) disable iff (!nrst)
    subband_upd |=> subband_reg == $past(subband_hw))
    else $error("sub-band update lost");
  subband_wr_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && addr == `SFRB_SUBBAND_ADDR && !subband_upd |=> subband_reg == $past(wdata[5:0]))
    else $error("sub-band host write lost");
  hold_pd_a: assert property (@(posedge clock) disable iff (!nrst)
    power_down && !wr_en && !subband_upd |=> $stable(narrow_reg) && $stable(reserved_reg))
    else $error("control changed in power-down");
  flag_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && addr == `SFRB_EVENT_FLAG_ADDR |=> !por_flag_reg)
    else $error("power-on flag not cleared");
  flag_rdback_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && addr == `SFRB_EVENT_FLAG_ADDR |=> rdata == {7'h00, $past(por_flag_reg)})
    else $error("power-on flag read wrong");
  reserved_rd_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && addr == `SFRB_RESERVED_ADDR |=> rdata == $past(reserved_reg))
    else $error("reserved byte read wrong");
  bank_route_a: assert property (@(posedge clock) disable iff (!nrst)
    addr >= `SFRB_BANK_FIRST && addr <= `SFRB_BANK_LAST
    |-> dif.region == (bank_sel_reg ? sfrb_pkg::SFRB_BANK1 : sfrb_pkg::SFRB_BANK0))
    else $error("upper window misrouted");
  bank1_rd_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && dif.region == sfrb_pkg::SFRB_BANK1 |=> rdata == $past(bank1_mem[dif.index]))
    else $error("bank 1 read wrong");
  sel_out_a: assert property (@(posedge clock) disable iff (!nrst)
    ##1 bank_sel_out == $past(bank_sel_reg))
    else $error("bank select output lags");
  bank1_cov: cover property (@(posedge clock) disable iff (!nrst)
    wr_en && dif.region == sfrb_pkg::SFRB_BANK1);
  subband_clash_cov: cover property (@(posedge clock) disable iff (!nrst)
    subband_upd && wr_en && addr == `SFRB_SUBBAND_ADDR);
  bank0_cov: cover property (@(posedge clock) disable iff (!nrst)
    rd_en && dif.region == sfrb_pkg::SFRB_BANK0);
  flag_cov: cover property (@(posedge clock) disable iff (!nrst) flag_rd && por_flag_reg);
endmodule // sfrb_regfile
`default_nettype wire
